// [rstseq.v]
// Reset sequencer, cause status and interrupt entry control
//
// The plain strobed port and the placing of the registers are this design's own decisions.
`timescale 1ns/1ns
`include "rstseq_map.vh"

module rstseq #(
    parameter WDOG_CYCLES = `WDOG_CYC,
    parameter NSRC = 16
) (
    input wire core_clk,
    input wire srst,
    input wire [15:0] reg_addr,
    input wire [7:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    output reg [7:0] reg_rdata,
    input wire power_up_pulse,
    input wire supply_low,
    input wire monitor_mode,
    input wire monitor_force,
    input wire opcode_fetch,
    input wire opcode_bad,
    input wire opcode_is_stop,
    input wire stop_enable,
    input wire fetch_unmapped,
    input wire rst_pin_in,
    output reg rst_pin_out,
    output reg rst_pin_oe,
    output reg core_reset,
    output reg clocks_hold,
    output reg bus_clk_en,
    output reg vec_fetch_start,
    output reg [15:0] reset_vec_addr,
    input wire insn_done,
    input wire i_bit,
    input wire soft_trap,
    input wire [NSRC-1:0] irq_req,
    input wire interrupt_return,
    output reg int_busy,
    output reg stack_push,
    output reg stack_pop,
    output reg [2:0] stack_sel,
    output reg stack_pc_minus1,
    output reg set_i_bit,
    output reg pc_load,
    output reg [15:0] int_vec_addr,
    output reg [4:0] int_prio
);

// ----------------------------------------
// Constants and helpers
// ----------------------------------------
localparam [2:0] S_IDLE = 3'd0;
localparam [2:0] S_SUPPLY = 3'd1;
localparam [2:0] S_SETTLE = 3'd2;
localparam [2:0] S_PINLOW = 3'd3;
localparam [2:0] S_HOLD = 3'd4;
localparam [2:0] S_EXT = 3'd5;

localparam [2:0] I_IDLE = 3'd0;
localparam [2:0] I_PUSH = 3'd1;
localparam [2:0] I_VEC = 3'd2;
localparam [2:0] I_POP = 3'd3;

// Stack slot codes
localparam [2:0] K_PCL = 3'd0;
localparam [2:0] K_PCH = 3'd1;
localparam [2:0] K_XL = 3'd2;
localparam [2:0] K_ACC = 3'd3;
localparam [2:0] K_CCR = 3'd4;

localparam [12:0] SETTLE_N = `SETTLE_CYC;
localparam [12:0] PINLOW_N = `PIN_LOW_CYC;
localparam [12:0] HOLD_N = `HOLD_CYC;
localparam [12:0] RSTLOW_N = `RST_LOW_CYC;

// Lowest index wins, so priority 0 is served before larger numbers
function [4:0] first_set;
    input [NSRC-1:0] v;
    integer k;
    begin
        first_set = 5'd0;
        for (k = NSRC - 1; k >= 0; k = k - 1) begin
            if (v[k]) begin
                first_set = k[4:0];
            end
        end
    end
endfunction

function [15:0] vec_of;
    input [4:0] prio;
    begin
        if (prio == 5'd0) begin
            vec_of = `VEC_SOFT_TRAP;
        end else begin
            vec_of = `VEC_IRQ_TOP - {10'd0, prio - 5'd1, 1'b0};
        end
    end
endfunction

// ----------------------------------------
// Pin synchroniser
// ----------------------------------------
reg pin_s1_reg, pin_s2_reg, pin_s3_reg;
reg pin_low_reg;
reg [12:0] ext_cnt_reg;

always @(posedge core_clk) begin
    if (srst) begin
        pin_s1_reg <= 1'b1;
        pin_s2_reg <= 1'b1;
        pin_s3_reg <= 1'b1;
        pin_low_reg <= 1'b0;
    end else begin
        pin_s1_reg <= rst_pin_in;
        pin_s2_reg <= pin_s1_reg;
        pin_s3_reg <= pin_s2_reg;
        // Level only changes once two stages agree
        if (pin_s2_reg == pin_s3_reg) begin
            pin_low_reg <= ~pin_s2_reg;
        end
    end
end

// ----------------------------------------
// Event decode
// ----------------------------------------
wire wdog_write = reg_wr && (reg_addr == `WDOG_CLR_ADDR);
wire rcs_read = reg_rd && (reg_addr == `RCS_ADDR);
reg [17:0] wdog_reg;
reg [2:0] state_reg;
reg [12:0] cnt_reg;
wire wdog_ovf = (state_reg == S_IDLE) &&
                ({14'd0, wdog_reg} == WDOG_CYCLES - 1);
wire bad_op = opcode_fetch &&
              (opcode_bad || (opcode_is_stop && !stop_enable));
// Data accesses never reach this term
wire bad_adr = opcode_fetch && fetch_unmapped;
wire ext_req = pin_low_reg && (ext_cnt_reg >= RSTLOW_N - 13'd1);
wire int_src = wdog_ovf || bad_op || bad_adr || monitor_force;

// ----------------------------------------
// Watchdog
// ----------------------------------------
always @(posedge core_clk) begin
    if (srst || state_reg != S_IDLE || wdog_write) begin
        wdog_reg <= 18'd0;
    end else begin
        wdog_reg <= wdog_reg + 18'd1;
    end
end

// ----------------------------------------
// Reset sequencer
// ----------------------------------------
reg internal_reg;
reg [7:0] rcs_reg;
reg [7:0] rcs_next;
reg [1:0] div_reg;

always @(posedge core_clk) begin
    if (srst || !pin_low_reg) begin
        ext_cnt_reg <= 13'd0;
    end else if (ext_cnt_reg != SETTLE_N) begin
        ext_cnt_reg <= ext_cnt_reg + 13'd1;
    end
end

always @(posedge core_clk) begin
    if (srst) begin
        state_reg <= S_SETTLE;
        cnt_reg <= 13'd0;
        internal_reg <= 1'b1;
        vec_fetch_start <= 1'b0;
        reset_vec_addr <= `VEC_RESET;
    end else begin
        vec_fetch_start <= 1'b0;
        cnt_reg <= cnt_reg + 13'd1;
        if (power_up_pulse) begin
            state_reg <= S_SETTLE;
            cnt_reg <= 13'd0;
            internal_reg <= 1'b1;
        end else if (supply_low) begin
            state_reg <= S_SUPPLY;
            cnt_reg <= 13'd0;
            internal_reg <= 1'b1;
        end else begin
            case (state_reg)
                S_IDLE: begin
                    cnt_reg <= 13'd0;
                    if (int_src) begin
                        state_reg <= S_PINLOW;
                        internal_reg <= 1'b1;
                    end else if (ext_req) begin
                        state_reg <= S_EXT;
                        internal_reg <= 1'b0;
                    end
                end
                S_SUPPLY: begin
                    cnt_reg <= 13'd0;
                    state_reg <= S_SETTLE;
                end
                S_SETTLE: begin
                    if (cnt_reg == SETTLE_N - 13'd1) begin
                        state_reg <= S_PINLOW;
                        cnt_reg <= 13'd0;
                    end
                end
                S_PINLOW: begin
                    if (cnt_reg == PINLOW_N - 13'd1) begin
                        state_reg <= S_HOLD;
                        cnt_reg <= 13'd0;
                    end
                end
                S_EXT: begin
                    cnt_reg <= 13'd0;
                    if (!pin_low_reg) begin
                        state_reg <= S_HOLD;
                    end
                end
                S_HOLD: begin
                    if (cnt_reg == HOLD_N - 13'd1) begin
                        state_reg <= S_IDLE;
                        vec_fetch_start <= 1'b1;
                        reset_vec_addr <= monitor_mode ?
                            `VEC_RESET_MON : `VEC_RESET;
                    end
                end
                default: begin
                    state_reg <= S_IDLE;
                end
            endcase
        end
    end
end

// Pin, hold and abort outputs, all registered
always @(posedge core_clk) begin
    if (srst) begin
        rst_pin_out <= 1'b0;
        rst_pin_oe <= 1'b1;
        core_reset <= 1'b1;
        clocks_hold <= 1'b1;
    end else begin
        rst_pin_out <= 1'b0;
        rst_pin_oe <= (state_reg == S_SUPPLY) || (state_reg == S_SETTLE)
                      || (state_reg == S_PINLOW);
        core_reset <= (state_reg != S_IDLE);
        clocks_hold <= (state_reg == S_SUPPLY) ||
                       (state_reg == S_SETTLE);
    end
end

// Divider restarts in reset so the bus always comes up at a quarter rate
always @(posedge core_clk) begin
    if (srst || state_reg != S_IDLE) begin
        div_reg <= 2'd0;
        bus_clk_en <= 1'b0;
    end else begin
        div_reg <= div_reg + 2'd1;
        bus_clk_en <= (div_reg == 2'd3);
    end
end

// ----------------------------------------
// Reset cause status
// ----------------------------------------
always @* begin
    // Read clear first, so a cause set this cycle survives it
    rcs_next = rcs_read ? 8'h00 : rcs_reg;
    if (state_reg == S_IDLE && int_src) begin
        rcs_next[`RCS_WDOG] = rcs_next[`RCS_WDOG] | wdog_ovf;
        rcs_next[`RCS_BADOP] = rcs_next[`RCS_BADOP] | bad_op;
        rcs_next[`RCS_BADADR] = rcs_next[`RCS_BADADR] | bad_adr;
        rcs_next[`RCS_MON] = rcs_next[`RCS_MON] | monitor_force;
    end
    if (state_reg == S_IDLE && !int_src && ext_req) begin
        rcs_next[`RCS_PIN] = 1'b1;
    end
    if (state_reg == S_HOLD && internal_reg &&
        cnt_reg == HOLD_N - 13'd1 && pin_low_reg) begin
        rcs_next[`RCS_PIN] = 1'b1;
    end
    if (supply_low) begin
        rcs_next[`RCS_LVI] = 1'b1;
    end
    if (power_up_pulse) begin
        rcs_next = 8'h00;
        rcs_next[`RCS_POR] = 1'b1;
        rcs_next[`RCS_LVI] = 1'b1;
    end
end

always @(posedge core_clk) begin
    if (srst) begin
        rcs_reg <= `RCS_POR_VALUE;
        reg_rdata <= 8'h00;
    end else begin
        rcs_reg <= rcs_next;
        // Writes to the status address are ignored
        reg_rdata <= rcs_read ? rcs_reg : 8'h00;
    end
end

// ----------------------------------------
// Interrupt entry and return
// ----------------------------------------
reg [2:0] ist_reg;
reg [2:0] step_reg;
reg recheck_reg;
wire boundary = (insn_done || recheck_reg) && !core_reset;
wire [NSRC-1:0] live = i_bit ? {NSRC{1'b0}} : irq_req;

always @(posedge core_clk) begin
    if (srst || core_reset) begin
        ist_reg <= I_IDLE;
        step_reg <= 3'd0;
        recheck_reg <= 1'b0;
        int_busy <= 1'b0;
        stack_push <= 1'b0;
        stack_pop <= 1'b0;
        stack_sel <= K_PCL;
        stack_pc_minus1 <= 1'b0;
        set_i_bit <= 1'b0;
        pc_load <= 1'b0;
        int_vec_addr <= `VEC_RESET;
        int_prio <= 5'd0;
    end else begin
        stack_push <= 1'b0;
        stack_pop <= 1'b0;
        set_i_bit <= 1'b0;
        pc_load <= 1'b0;
        recheck_reg <= 1'b0;
        case (ist_reg)
            I_IDLE: begin
                step_reg <= 3'd0;
                if (interrupt_return) begin
                    ist_reg <= I_POP;
                    int_busy <= 1'b1;
                end else if (boundary && soft_trap) begin
                    ist_reg <= I_PUSH;
                    int_busy <= 1'b1;
                    int_prio <= 5'd0;
                    int_vec_addr <= `VEC_SOFT_TRAP;
                    stack_pc_minus1 <= 1'b0;
                end else if (boundary && |live) begin
                    ist_reg <= I_PUSH;
                    int_busy <= 1'b1;
                    int_prio <= first_set(live) + 5'd1;
                    int_vec_addr <= vec_of(first_set(live) + 5'd1);
                    stack_pc_minus1 <= 1'b1;
                end
            end
            I_PUSH: begin
                // Source is latched; requests here cannot preempt it
                stack_push <= 1'b1;
                stack_sel <= step_reg;
                step_reg <= step_reg + 3'd1;
                if (step_reg == K_CCR) begin
                    ist_reg <= I_VEC;
                end
            end
            I_VEC: begin
                set_i_bit <= 1'b1;
                pc_load <= 1'b1;
                int_busy <= 1'b0;
                ist_reg <= I_IDLE;
            end
            I_POP: begin
                // Pops run in reverse of the push order
                stack_pop <= 1'b1;
                stack_sel <= K_CCR - step_reg;
                step_reg <= step_reg + 3'd1;
                if (step_reg == K_CCR) begin
                    ist_reg <= I_IDLE;
                    int_busy <= 1'b0;
                    recheck_reg <= 1'b1;
                end
            end
            default: begin
                ist_reg <= I_IDLE;
            end
        endcase
    end
end

endmodule

// [rstseq_assertions.sv]
// Assertion checker for the reset sequencer
`timescale 1ns/1ns
module rstseq_assertions #(
    parameter NSRC = 16
) (
    input wire core_clk, srst, reg_rd, opcode_fetch, opcode_bad,
    input wire supply_low, monitor_mode, rst_pin_out, rst_pin_oe,
    input wire core_reset, clocks_hold, bus_clk_en, vec_fetch_start,
    input wire insn_done, i_bit, soft_trap, interrupt_return, int_busy,
    input wire stack_push, stack_pop, stack_pc_minus1, pc_load, set_i_bit,
    input wire [7:0] reg_rdata,
    input wire [15:0] reset_vec_addr, int_vec_addr,
    input wire [2:0] stack_sel,
    input wire [NSRC-1:0] irq_req
);
    // ----------------------------------------
    // Run length counters
    // ----------------------------------------
    // Settle count skips low supply time, which has no fixed length
    reg [12:0] oe_cnt;
    reg [12:0] hold_cnt;
    always @(posedge core_clk) begin
        if (srst || !rst_pin_oe) begin
            oe_cnt <= 13'h0;
        end else begin
            oe_cnt <= oe_cnt + 13'h1;
        end
        if (srst || !clocks_hold) begin
            hold_cnt <= 13'h0;
        end else if (!supply_low) begin
            hold_cnt <= hold_cnt + 13'h1;
        end
    end

    // ----------------------------------------
    // Properties
    // ----------------------------------------
    default clocking dc @(posedge core_clk); endclocking
    default disable iff (srst);
    sequence pushes;
        stack_push && stack_sel == 3'h0 ##1 stack_push && stack_sel == 3'h1
        ##1 stack_push && stack_sel == 3'h2 ##1 stack_push && stack_sel == 3'h3
        ##1 stack_push && stack_sel == 3'h4;
    endsequence
    sequence pops;
        stack_pop && stack_sel == 3'h4 ##1 stack_pop && stack_sel == 3'h3
        ##1 stack_pop && stack_sel == 3'h2 ##1 stack_pop && stack_sel == 3'h1
        ##1 stack_pop && stack_sel == 3'h0;
    endsequence

    pin_drive_a: assert property (
        rst_pin_oe |-> !rst_pin_out && core_reset)
        else $error("pin pulled outside reset");
    // Outputs are registered from the state, so they answer two edges late
    bad_op_a: assert property (
        opcode_fetch && opcode_bad && !core_reset
        |=> ##1 rst_pin_oe && core_reset)
        else $error("bad opcode ignored");
    pin_len_a: assert property (
        $fell(rst_pin_oe) |-> oe_cnt == 13'h20 || oe_cnt > 13'hfa0)
        else $error("pin low length");
    hold_tail_a: assert property (
        $fell(rst_pin_oe) |-> ##31 core_reset ##1 !core_reset)
        else $error("hold after pin");
    settle_len_a: assert property (
        $fell(clocks_hold) |-> hold_cnt >= 13'hfff && hold_cnt <= 13'h1004)
        else $error("settle");
    settle_pin_a: assert property (
        $fell(clocks_hold) |-> rst_pin_oe ##[31:33] !rst_pin_oe)
        else $error("pin after settle");
    bus_clk_a: assert property (
        bus_clk_en |-> !core_reset ##1 !bus_clk_en[*3]
        ##1 (bus_clk_en || core_reset))
        else $error("bus clock");
    reset_vec_a: assert property (
        vec_fetch_start
        |-> reset_vec_addr == (monitor_mode ? 16'hfefe : 16'hfffe))
        else $error("reset vector");
    rdata_idle_a: assert property (
        !$past(reg_rd) |-> reg_rdata == 8'h00)
        else $error("read data outside slot");
    // A return in the same cycle outranks entry, so it is kept out
    irq_entry_a: assert property (
        insn_done && irq_req[0] && !i_bit && !soft_trap && !int_busy
        && !core_reset && !interrupt_return
        |=> int_busy ##1 pushes
        ##1 set_i_bit && pc_load && int_vec_addr == 16'hfffa)
        else $error("interrupt entry");
    mask_a: assert property (
        insn_done && i_bit && !soft_trap && !int_busy && !interrupt_return
        |=> !int_busy)
        else $error("masked request taken");
    soft_trap_a: assert property (
        insn_done && soft_trap && !int_busy && !core_reset && !interrupt_return
        |-> ##2 (stack_push && !stack_pc_minus1)
        ##5 (pc_load && int_vec_addr == 16'hfffc))
        else $error("soft trap");
    no_preempt_a: assert property (
        $rose(stack_push) |-> $stable(int_vec_addr)[*5])
        else $error("entry preempted");
    return_a: assert property (
        interrupt_return && !int_busy && !core_reset |-> ##[1:3] pops)
        else $error("return pop order");
endmodule

bind rstseq rstseq_assertions #(.NSRC(NSRC)) i_rstseq_assertions (.*);

// [rstseq_map.vh]
// Constants for the reset sequencer and interrupt entry block
`ifndef RSTSEQ_MAP_VH
`define RSTSEQ_MAP_VH

// ----------------------------------------
// Addresses
// ----------------------------------------
`define WDOG_CLR_ADDR 16'hffff
`define RCS_ADDR 16'hfe01
`define VEC_RESET 16'hfffe
`define VEC_RESET_MON 16'hfefe
`define VEC_SOFT_TRAP 16'hfffc
`define VEC_IRQ_TOP 16'hfffa

// ----------------------------------------
// Status bit positions
// ----------------------------------------
`define RCS_POR 7
`define RCS_PIN 6
`define RCS_WDOG 5
`define RCS_BADOP 4
`define RCS_BADADR 3
`define RCS_MON 2
`define RCS_LVI 1
`define RCS_POR_VALUE 8'h80

// ----------------------------------------
// Timing
// ----------------------------------------
`define CLK_PERIOD_NS 40
`define RST_LOW_TIME_NS 100
`define RST_LOW_CYC ((`RST_LOW_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define PIN_LOW_CYC 32
`define HOLD_CYC 32
`define SETTLE_CYC 4096
`define WDOG_CYC 262144

`endif

// [rstseq_partner.sv]
// Model of the CPU core and of the devices sharing the reset pin
`timescale 1ns/1ns
module rstseq_partner (
    input wire core_clk, srst, core_reset, int_busy, set_i_bit,
    input wire stack_pop, rst_pin_oe, rst_pin_out,
    input wire ext_low, mask_set, mask_clr,
    input wire [2:0] stack_sel,
    output wire rst_pin_in,
    output reg insn_done,
    output reg i_bit
);
    reg [1:0] step_reg;

    // Pin has a pull-up, so a released line reads high
    assign rst_pin_in = !((rst_pin_oe && !rst_pin_out) || ext_low);

    always @(posedge core_clk) begin
        if (srst || core_reset) begin
            step_reg <= 2'h0;
            insn_done <= 1'b0;
            i_bit <= 1'b1;
        end else begin
            // Four-cycle instructions; none retire during entry or return
            step_reg <= step_reg + 2'h1;
            insn_done <= (step_reg == 2'h2) && !int_busy;
            if (set_i_bit || mask_set) begin
                i_bit <= 1'b1;
            end else if ((stack_pop && stack_sel == 3'h4) || mask_clr) begin
                i_bit <= 1'b0;
            end
        end
    end
endmodule

// [rstseq_tb.sv]
// Self-checking testbench for the reset sequencer
`timescale 1ns/1ns
module rstseq_tb;
    reg core_clk = 1'b0;
    reg srst = 1'b1;
    reg [15:0] reg_addr = 16'h0;
    reg [7:0] reg_wdata = 8'h0;
    reg reg_wr = 1'b0, reg_rd = 1'b0, power_up_pulse = 1'b0;
    reg supply_low = 1'b0, monitor_mode = 1'b0, monitor_force = 1'b0;
    reg opcode_fetch = 1'b0, opcode_bad = 1'b0, opcode_is_stop = 1'b0;
    reg stop_enable = 1'b1, fetch_unmapped = 1'b0, soft_trap = 1'b0;
    reg interrupt_return = 1'b0, ext_low = 1'b0;
    reg mask_set = 1'b0, mask_clr = 1'b0;
    reg [15:0] irq_req = 16'h0;
    wire [7:0] reg_rdata;
    wire rst_pin_in, rst_pin_out, rst_pin_oe, core_reset, clocks_hold;
    wire bus_clk_en, vec_fetch_start, insn_done, i_bit, int_busy;
    wire stack_push, stack_pop, stack_pc_minus1, set_i_bit, pc_load;
    wire [15:0] reset_vec_addr, int_vec_addr;
    wire [2:0] stack_sel;
    wire [4:0] int_prio;
    integer error_cnt = 0, num_checks = 0, cyc = 0, loads = 0, l0;

    // Short watchdog keeps the overflow case brief
    rstseq #(.WDOG_CYCLES(512)) i_rstseq (.*);
    rstseq_partner i_rstseq_partner (.*);

    initial forever #20 core_clk = ~core_clk;

    // ----------------------------------------
    // Hang guard, entry counter and tasks
    // ----------------------------------------
    always @(posedge core_clk) begin
        cyc = cyc + 1;
        if (pc_load === 1'b1) loads = loads + 1;
        if (cyc == 30000) begin
            error_cnt = error_cnt + 1;
            end_of_test;
        end
    end

    task chk(input [15:0] got, input [15:0] exp);
        num_checks = num_checks + 1;
        if (got !== exp) begin
            error_cnt = error_cnt + 1;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    task end_of_test;
        $display("checks %0d errors %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    task wr(input [15:0] a, input [7:0] d);
        @(posedge core_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge core_clk);
        reg_wr <= 1'b0;
    endtask
    task rd(input [15:0] a, input [7:0] e);
        @(posedge core_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        #1;
        chk(reg_rdata, e);
        // Back onto the edge so later stimulus stays edge aligned
        @(posedge core_clk);
    endtask
    // Bits: power-up, monitor force, fetch, bad, stop, unmapped
    task ev(input [5:0] m);
        @(posedge core_clk);
        {power_up_pulse, monitor_force, opcode_fetch, opcode_bad,
            opcode_is_stop, fetch_unmapped} <= m;
        @(posedge core_clk);
        {power_up_pulse, monitor_force, opcode_fetch, opcode_bad,
            opcode_is_stop, fetch_unmapped} <= 6'h00;
    endtask
    task run_out;
        repeat (700) if (core_reset !== 1'b1) @(posedge core_clk);
        repeat (9000) if (core_reset !== 1'b0) @(posedge core_clk);
    endtask
    task recover(input [7:0] f, input [15:0] v);
        run_out;
        chk(reset_vec_addr, v);
        rd(16'hfe01, f);
    endtask
    task wait_load;
        l0 = loads;
        repeat (40) if (loads == l0) @(posedge core_clk);
    endtask

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        repeat (8) @(posedge core_clk);
        srst <= 1'b0;
        @(posedge core_clk);
        #1;
        chk({rst_pin_oe, core_reset, clocks_hold}, 16'h7);
        recover(8'h80, 16'hfffe);
        rd(16'hfe01, 8'h00);
        wr(16'hfe01, 8'hff);
        rd(16'hfe01, 8'h00);
        rd(16'h1234, 8'h00);
        ev(6'h01);
        ev(6'h0a);
        repeat (20) @(posedge core_clk);
        chk(core_reset, 1'b0);
        ev(6'h0c);
        run_out;
        ev(6'h09);
        recover(8'h18, 16'hfffe);
        stop_enable <= 1'b0;
        ev(6'h0a);
        recover(8'h10, 16'hfffe);
        monitor_mode <= 1'b1;
        ev(6'h10);
        recover(8'h04, 16'hfefe);
        monitor_mode <= 1'b0;
        wr(16'hffff, 8'h5a);
        repeat (400) @(posedge core_clk);
        wr(16'hffff, 8'h00);
        repeat (400) @(posedge core_clk);
        chk(core_reset, 1'b0);
        recover(8'h20, 16'hfffe);
        ext_low <= 1'b1;
        repeat (10) @(posedge core_clk);
        ext_low <= 1'b0;
        recover(8'h40, 16'hfffe);
        supply_low <= 1'b1;
        repeat (30) @(posedge core_clk);
        supply_low <= 1'b0;
        recover(8'h02, 16'hfffe);
        ev(6'h0c);
        run_out;
        ev(6'h20);
        recover(8'h82, 16'hfffe);
        wr(16'hffff, 8'h33);
        mask_clr <= 1'b1;
        irq_req <= 16'h0005;
        @(posedge core_clk);
        mask_clr <= 1'b0;
        wait_load;
        chk(int_vec_addr, 16'hfffa);
        chk(int_prio, 5'h01);
        chk(stack_pc_minus1, 1'b1);
        irq_req <= 16'h0004;
        interrupt_return <= 1'b1;
        @(posedge core_clk);
        interrupt_return <= 1'b0;
        wait_load;
        chk(int_vec_addr, 16'hfff6);
        chk(int_prio, 5'h03);
        irq_req <= 16'h0000;
        interrupt_return <= 1'b1;
        @(posedge core_clk);
        interrupt_return <= 1'b0;
        repeat (12) @(posedge core_clk);
        mask_set <= 1'b1;
        @(posedge core_clk);
        mask_set <= 1'b0;
        irq_req <= 16'h0001;
        l0 = loads;
        repeat (30) @(posedge core_clk);
        chk(loads[15:0], l0[15:0]);
        soft_trap <= 1'b1;
        wait_load;
        soft_trap <= 1'b0;
        chk(int_vec_addr, 16'hfffc);
        chk(int_prio, 5'h00);
        chk(stack_pc_minus1, 1'b0);
        irq_req <= 16'h0000;
        repeat (10) @(posedge core_clk);
        end_of_test;
    end
endmodule
